// >>> hdl/frame_pkg.sv
// Constants shared by both ends of the compressed field stream link.
// Assumes a 32-bit word link, markers always occupying whole words.
package frame_pkg;

    // ========================================
    // Word and field widths
    localparam int WORD_W = 32;
    localparam int BW_W = 16;
    localparam int TC_BITS = 96;
    localparam int TC_CONTENT_BITS = 90;
    localparam logic [1:0] TC_LAST = 2'h2;

    // ========================================
    // Delimiter codes
    localparam logic [31:0] SOF_HI = 32'hFFFFFFFF;
    localparam logic [31:0] FIELD_ONE_START_MARKER_LO = 32'h40000000;
    localparam logic [31:0] FIELD_TWO_START_MARKER_LO = 32'h41000000;
    localparam logic [23:0] MARK_PREFIX = 24'hFFFFFF;
    localparam logic [7:0] KIND1 = 8'h81;
    localparam logic [7:0] KIND2 = 8'h82;
    localparam logic [7:0] KIND3 = 8'h83;
    localparam logic [7:0] KIND4 = 8'h84;
    localparam logic [7:0] ZERO_KIND = 8'h85;
    localparam logic [7:0] NO_KIND = 8'h00;
    localparam logic [31:0] EOS_CODE = 32'hFFFFFF87;
    localparam logic [7:0] FIRST_TYPE = 8'h84;

    // ========================================
    // Block transfer order, index 0 is the first block
    localparam int BLOCK_COUNT = 42;
    localparam logic [5:0] LAST_IDX = 6'h29;
    localparam logic [5:0] BLOCK_ORDER [0:41] = '{
        6'h06, 6'h09,
        6'h14, 6'h16, 6'h13, 6'h17, 6'h11, 6'h19, 6'h10, 6'h1A, 6'h0E, 6'h1C, 6'h0D, 6'h1D,
        6'h0B, 6'h1F, 6'h0A, 6'h20, 6'h08, 6'h22, 6'h07, 6'h23,
        6'h05, 6'h25, 6'h04, 6'h26, 6'h02, 6'h28, 6'h01, 6'h29,
        6'h00, 6'h27, 6'h0C, 6'h24, 6'h0F, 6'h21, 6'h12, 6'h1E,
        6'h15, 6'h1B, 6'h18, 6'h03
    };
    localparam logic [7:0] BLOCK_KIND [0:41] = '{
        NO_KIND, KIND4,
        KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3, KIND3,
        KIND3, KIND1, KIND3, KIND1, KIND3, KIND1, KIND3, KIND1,
        KIND3, KIND1, KIND3, KIND1, KIND3, KIND1, KIND3, KIND1,
        KIND4, KIND2, KIND4, KIND2, KIND4, KIND2, KIND4, KIND2,
        KIND2, KIND2, KIND2, KIND4
    };

endpackage

// >>> hdl/frame_link_if.sv
// Word link between the stream builder and the stream parser.
// Assumes both ends share one clock and one clock enable.
`timescale 1ns/100ps

interface frame_link_if;
    logic [31:0] data;
    logic valid;
    logic ready;

    modport host (
        output data,
        output valid,
        input ready
    );

    modport dev (
        input data,
        input valid,
        output ready
    );
endinterface

// >>> hdl/stream_builder.sv
// Host end: builds field sequences and the sequence end word.
// Assumes the user holds block inputs stable while block_num_o names the block.
`timescale 1ns/100ps

module stream_builder (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Link toward the parsing end
    frame_link_if.host link,
    // Field and sequence control
    input wire logic field_start_i,
    input wire logic eos_req_i,
    input wire logic [frame_pkg::TC_BITS-1:0] timecode_i,
    // Per-block inputs
    input wire logic [frame_pkg::BW_W-1:0] bin_width_i,
    input wire logic block_empty_i,
    // Payload words
    input wire logic [31:0] pay_data_i,
    input wire logic pay_valid_i,
    input wire logic pay_last_i,
    output logic pay_ready_o,
    // Status
    output logic [5:0] block_num_o,
    output logic field_two_o,
    output logic busy_o
);

    typedef enum logic [3:0] {
        B_IDLE = 4'h0,
        B_SOF_HI = 4'h1,
        B_SOF_LO = 4'h2,
        B_TC = 4'h3,
        B_FIRST = 4'h4,
        B_MARK = 4'h5,
        B_BW = 4'h6,
        B_PAY = 4'h7,
        B_NEXT = 4'h8,
        B_EOS = 4'h9
    } build_state_type;

    build_state_type st_q, st_d;
    logic [31:0] data_q, data_d;
    logic valid_q, valid_d;
    logic [5:0] idx_q, idx_d;
    logic [1:0] tc_q, tc_d;
    logic empty_q, empty_d;
    logic field_q, field_d;
    logic pay_ready_q, pay_ready_d;
    logic [5:0] block_num_q;
    logic busy_q;

    // ========================================
    // Selection
    wire slot_free = !valid_q || link.ready;
    wire pay_load = pay_valid_i && pay_ready_q;
    wire last_block = idx_q == frame_pkg::LAST_IDX;
    wire [31:0] tc_word = (tc_q == 2'h0) ? timecode_i[95:64] :
                          (tc_q == 2'h1) ? timecode_i[63:32] : timecode_i[31:0];
    wire [7:0] mark_kind = block_empty_i ? frame_pkg::ZERO_KIND : frame_pkg::BLOCK_KIND[idx_q];

    assign link.data = data_q;
    assign link.valid = valid_q;
    assign pay_ready_o = pay_ready_q;
    assign block_num_o = block_num_q;
    assign field_two_o = field_q;
    assign busy_o = busy_q;

    // ========================================
    // Sequencing
    always_comb begin
        st_d = st_q;
        data_d = data_q;
        valid_d = valid_q && !link.ready;
        idx_d = idx_q;
        tc_d = tc_q;
        empty_d = empty_q;
        field_d = field_q;
        pay_ready_d = 1'b0;
        case (st_q)
            B_IDLE: begin
                if (field_start_i) begin
                    st_d = B_SOF_HI;
                end else if (eos_req_i) begin
                    st_d = B_EOS;
                end
            end
            B_SOF_HI: if (slot_free) begin
                data_d = frame_pkg::SOF_HI; // see RULE9
                valid_d = 1'b1;
                st_d = B_SOF_LO;
            end
            B_SOF_LO: if (slot_free) begin
                data_d = field_q ? frame_pkg::FIELD_TWO_START_MARKER_LO : frame_pkg::FIELD_ONE_START_MARKER_LO; // see RULE9
                valid_d = 1'b1;
                tc_d = 2'h0;
                st_d = B_TC;
            end
            B_TC: if (slot_free) begin
                data_d = tc_word; // see RULE12
                valid_d = 1'b1;
                tc_d = tc_q + 2'h1;
                if (tc_q == frame_pkg::TC_LAST) begin
                    st_d = B_FIRST;
                end
            end
            B_FIRST: if (slot_free) begin
                // Type code and bin width share one word; no delimiter ahead
                data_d = {frame_pkg::FIRST_TYPE, 8'h00, bin_width_i}; // see RULE3 see RULE11 see RULE13
                valid_d = 1'b1;
                idx_d = 6'h00;
                empty_d = block_empty_i;
                st_d = block_empty_i ? B_NEXT : B_PAY;
            end
            B_MARK: if (slot_free) begin
                data_d = {frame_pkg::MARK_PREFIX, mark_kind}; // see RULE2 see RULE7 see RULE10
                valid_d = 1'b1;
                empty_d = block_empty_i;
                st_d = B_BW;
            end
            B_BW: if (slot_free) begin
                data_d = {16'h0000, bin_width_i}; // see RULE2 see RULE13
                valid_d = 1'b1;
                st_d = empty_q ? B_NEXT : B_PAY;
            end
            B_PAY: begin
                // Ready only while the output slot is empty, so no word is dropped
                pay_ready_d = !pay_load && slot_free;
                if (pay_load) begin
                    data_d = pay_data_i;
                    valid_d = 1'b1;
                    if (pay_last_i) begin
                        st_d = B_NEXT;
                    end
                end
            end
            B_NEXT: begin
                if (last_block) begin
                    // Point back at block 6 so the next header sends its width
                    idx_d = 6'h00;
                    field_d = !field_q; // see RULE8
                    st_d = B_IDLE;
                end else begin
                    idx_d = idx_q + 6'h01; // see RULE1 see RULE4 see RULE5 see RULE6
                    st_d = B_MARK;
                end
            end
            B_EOS: if (slot_free) begin
                data_d = frame_pkg::EOS_CODE; // see RULE8
                valid_d = 1'b1;
                field_d = 1'b0;
                st_d = B_IDLE;
            end
            default: st_d = B_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= B_IDLE;
            data_q <= 32'h00000000;
            valid_q <= 1'b0;
            idx_q <= 6'h00;
            tc_q <= 2'h0;
            empty_q <= 1'b0;
            field_q <= 1'b0;
            pay_ready_q <= 1'b0;
            block_num_q <= 6'h06;
            busy_q <= 1'b0;
        end else if (ce_i) begin
            st_q <= st_d;
            data_q <= data_d;
            valid_q <= valid_d;
            idx_q <= idx_d;
            tc_q <= tc_d;
            empty_q <= empty_d;
            field_q <= field_d;
            pay_ready_q <= pay_ready_d;
            block_num_q <= frame_pkg::BLOCK_ORDER[idx_d];
            busy_q <= (st_d != B_IDLE) || valid_d;
        end
    end

endmodule

// >>> hdl/stream_parser.sv
// Device end: parses field sequences from the word link in decode.
// Assumes payload words never begin with the all-ones delimiter prefix.
//
// What this block does
// RULE1: First block then 41 further blocks.
// RULE2: Block is marker, bin width, payload.
// RULE3: Field marker, timecode, type, width, block 6 payload.
// RULE4: Block 9 kind four, then twelve kind three.
// RULE5: Sixteen blocks alternate kind three and one.
// RULE6: Tail uses kinds four and two, block 3 last.
// RULE7: Zero-data marker may replace any block marker.
// RULE8: Fields alternate; sequence end marker closes decode.
// RULE9: Field markers are fixed; they restart decoding. Here one that arrives among the timecode words is taken as timecode instead.
// RULE10: Delimiters start on 32-bit word boundaries.
// RULE11: First block type code is 8-bit 0x84.
// RULE12: Timecode takes 12 bytes, 90 carry content.
// RULE13: Bin width is a 16-bit value.
`timescale 1ns/100ps

module stream_parser (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Link from the building end
    frame_link_if.dev link,
    // Field information
    output logic field_two_o,
    output logic field_start_o,
    output logic decoder_reset_o,
    output logic [frame_pkg::TC_BITS-1:0] timecode_o,
    output logic timecode_valid_o,
    output logic [7:0] first_type_o,
    // Block information
    output logic block_start_o,
    output logic [5:0] block_num_o,
    output logic zero_block_o,
    output logic [frame_pkg::BW_W-1:0] bin_width_o,
    output logic bin_width_valid_o,
    // Payload words
    output logic [31:0] pay_data_o,
    output logic pay_valid_o,
    // Sequence status
    output logic seq_end_o,
    output logic order_err_o
);

    typedef enum logic [2:0] {
        P_HUNT = 3'h0,
        P_SOF_LO = 3'h1,
        P_TC = 3'h2,
        P_FIRST = 3'h3,
        P_BW = 3'h4,
        P_PAY = 3'h5
    } parse_state_type;

    parse_state_type st_q, st_d;
    logic ready_q;
    logic [5:0] idx_q, idx_d;
    logic [1:0] tc_cnt_q, tc_cnt_d;
    logic seen_q, seen_d;
    logic field_q, field_d;
    logic [95:0] tc_q, tc_d;
    logic [7:0] type_q, type_d;
    logic [5:0] blk_q, blk_d;
    logic zero_q, zero_d;
    logic [15:0] bw_q, bw_d;
    logic [31:0] pay_q, pay_d;
    logic fstart_q, fstart_d;
    logic tcv_q, tcv_d;
    logic bstart_q, bstart_d;
    logic bwv_q, bwv_d;
    logic payv_q, payv_d;
    logic eos_q, eos_d;
    logic err_q, err_d;

    // ========================================
    // Word decoding
    wire take = link.valid && ready_q;
    wire [31:0] w = link.data;
    wire is_sof_hi = w == frame_pkg::SOF_HI;
    wire is_eos = w == frame_pkg::EOS_CODE;
    wire is_mark = (w[31:8] == frame_pkg::MARK_PREFIX) && !is_sof_hi; // see RULE10
    wire is_sof_lo = (w == frame_pkg::FIELD_ONE_START_MARKER_LO) || (w == frame_pkg::FIELD_TWO_START_MARKER_LO);
    wire is_zero = w[7:0] == frame_pkg::ZERO_KIND;
    wire room = idx_q != frame_pkg::LAST_IDX;
    wire [5:0] next_idx = idx_q + 6'h01;
    wire [7:0] kind_exp = room ? frame_pkg::BLOCK_KIND[next_idx] : frame_pkg::NO_KIND;
    wire kind_ok = room && (is_zero || (w[7:0] == kind_exp));

    assign link.ready = ready_q;
    assign field_two_o = field_q;
    assign field_start_o = fstart_q;
    assign decoder_reset_o = fstart_q;
    assign timecode_o = tc_q;
    assign timecode_valid_o = tcv_q;
    assign first_type_o = type_q;
    assign block_start_o = bstart_q;
    assign block_num_o = blk_q;
    assign zero_block_o = zero_q;
    assign bin_width_o = bw_q;
    assign bin_width_valid_o = bwv_q;
    assign pay_data_o = pay_q;
    assign pay_valid_o = payv_q;
    assign seq_end_o = eos_q;
    assign order_err_o = err_q;

    // ========================================
    // Parsing
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        tc_cnt_d = tc_cnt_q;
        seen_d = seen_q;
        field_d = field_q;
        tc_d = tc_q;
        type_d = type_q;
        blk_d = blk_q;
        zero_d = zero_q;
        bw_d = bw_q;
        pay_d = pay_q;
        fstart_d = 1'b0;
        tcv_d = 1'b0;
        bstart_d = 1'b0;
        bwv_d = 1'b0;
        payv_d = 1'b0;
        eos_d = 1'b0;
        err_d = 1'b0;
        if (take && is_sof_hi && (st_q != P_TC)) begin
            // A field marker is honoured anywhere except among the timecode words, even mid-field
            st_d = P_SOF_LO; // see RULE9
        end else if (take) begin
            case (st_q)
                P_HUNT: begin
                    if (is_eos) begin
                        eos_d = 1'b1; // see RULE8
                        seen_d = 1'b0;
                    end
                end
                P_SOF_LO: begin
                    if (is_sof_lo) begin
                        field_d = w == frame_pkg::FIELD_TWO_START_MARKER_LO; // see RULE9
                        err_d = seen_q && ((w == frame_pkg::FIELD_TWO_START_MARKER_LO) == field_q); // see RULE8
                        seen_d = 1'b1;
                        fstart_d = 1'b1;
                        tc_cnt_d = 2'h0;
                        st_d = P_TC;
                    end else begin
                        err_d = 1'b1;
                        st_d = P_HUNT;
                    end
                end
                P_TC: begin
                    tc_d = {tc_q[63:0], w}; // see RULE12
                    tc_cnt_d = tc_cnt_q + 2'h1;
                    if (tc_cnt_q == frame_pkg::TC_LAST) begin
                        tcv_d = 1'b1;
                        st_d = P_FIRST;
                    end
                end
                P_FIRST: begin
                    type_d = w[31:24]; // see RULE11
                    err_d = w[31:24] != frame_pkg::FIRST_TYPE;
                    bw_d = w[15:0]; // see RULE13
                    bwv_d = 1'b1;
                    idx_d = 6'h00;
                    blk_d = frame_pkg::BLOCK_ORDER[0]; // see RULE3
                    bstart_d = 1'b1;
                    zero_d = 1'b0;
                    st_d = P_PAY;
                end
                P_BW: begin
                    bw_d = w[15:0]; // see RULE2 see RULE13
                    bwv_d = 1'b1;
                    st_d = P_PAY;
                end
                P_PAY: begin
                    if (is_eos) begin
                        eos_d = 1'b1; // see RULE8
                        err_d = room;
                        seen_d = 1'b0;
                        st_d = P_HUNT;
                    end else if (is_mark) begin
                        // Wrong kind is flagged but parsing keeps the fixed order
                        err_d = !kind_ok; // see RULE4 see RULE5 see RULE6 see RULE7
                        idx_d = room ? next_idx : idx_q; // see RULE1
                        blk_d = frame_pkg::BLOCK_ORDER[room ? next_idx : idx_q];
                        zero_d = is_zero; // see RULE7
                        bstart_d = 1'b1;
                        st_d = P_BW; // see RULE2
                    end else begin
                        pay_d = w;
                        payv_d = 1'b1;
                        err_d = zero_q;
                    end
                end
                default: st_d = P_HUNT;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_q <= P_HUNT;
            ready_q <= 1'b0;
            idx_q <= 6'h00;
            tc_cnt_q <= 2'h0;
            seen_q <= 1'b0;
            field_q <= 1'b0;
            tc_q <= 96'h0;
            type_q <= 8'h00;
            blk_q <= 6'h00;
            zero_q <= 1'b0;
            bw_q <= 16'h0000;
            pay_q <= 32'h00000000;
        end else if (ce_i) begin
            st_q <= st_d;
            ready_q <= 1'b1;
            idx_q <= idx_d;
            tc_cnt_q <= tc_cnt_d;
            seen_q <= seen_d;
            field_q <= field_d;
            tc_q <= tc_d;
            type_q <= type_d;
            blk_q <= blk_d;
            zero_q <= zero_d;
            bw_q <= bw_d;
            pay_q <= pay_d;
        end
    end

    // ========================================
    // One-cycle strobes
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fstart_q <= 1'b0;
            tcv_q <= 1'b0;
            bstart_q <= 1'b0;
            bwv_q <= 1'b0;
            payv_q <= 1'b0;
            eos_q <= 1'b0;
            err_q <= 1'b0;
        end else if (ce_i) begin
            fstart_q <= fstart_d;
            tcv_q <= tcv_d;
            bstart_q <= bstart_d;
            bwv_q <= bwv_d;
            payv_q <= payv_d;
            eos_q <= eos_d;
            err_q <= err_d;
        end
    end

endmodule

// >>> bench/frame_link_sva.sv
// Checker for the word link between the stream builder and the stream parser.
// Assumes the bench instantiates it beside the interface with the shared clock and enable.
`timescale 1ns/100ps

module frame_link_sva (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Link signals
    input wire logic [31:0] data,
    input wire logic valid,
    input wire logic ready
);
    // ========================================
    // Word tracking
    logic [2:0] widx_q;
    logic [5:0] mk_q;
    logic mark_q;
    logic open_q;
    logic seen_q;
    logic fld_q;
    wire tk = ce_i && valid && ready;
    wire is_hi = data == frame_pkg::SOF_HI;
    wire is_eos = data == frame_pkg::EOS_CODE;
    wire is_mark = data[31:8] == frame_pkg::MARK_PREFIX && !is_hi && !is_eos;
    wire [5:0] nx = mk_q + 6'h01;
    // Kind from position ranges, kept apart from the package table on purpose
    wire [7:0] kind = (nx == 6'h01 || nx == 6'h29) ? 8'h84 : (nx < 6'h0E) ? 8'h83 :
        (nx < 6'h1E) ? (nx[0] ? 8'h81 : 8'h83) : (nx < 6'h26) ? (nx[0] ? 8'h82 : 8'h84) : 8'h82;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            widx_q <= 3'h7;
            mk_q <= 6'h00;
            mark_q <= 1'b0;
            open_q <= 1'b0;
            seen_q <= 1'b0;
            fld_q <= 1'b0;
        end else if (tk) begin
            widx_q <= is_hi ? 3'h1 : (widx_q == 3'h7 ? widx_q : widx_q + 3'h1);
            mk_q <= is_hi ? 6'h00 : mk_q + {5'h00, is_mark};
            mark_q <= is_mark;
            open_q <= is_hi || (open_q && !is_eos);
            seen_q <= !is_eos && (seen_q || widx_q == 3'h1);
            fld_q <= (widx_q == 3'h1) ? data[24] : fld_q;
        end
    end

    // ========================================
    // Properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_HOLD: assert property (valid && !(ce_i && ready) |=> valid && $stable(data))
        else $error("Link word changed before it was taken");
    AST_SOF_LO: assert property (tk && widx_q == 3'h1 |-> data == frame_pkg::FIELD_ONE_START_MARKER_LO || data == frame_pkg::FIELD_TWO_START_MARKER_LO)
        else $error("Field marker low word wrong");
    AST_ALT: assert property (tk && widx_q == 3'h1 && seen_q |-> data[24] != fld_q)
        else $error("Field did not alternate");
    AST_FIRST: assert property (tk && widx_q == 3'h5 |-> data[31:16] == {frame_pkg::FIRST_TYPE, 8'h00})
        else $error("First block word wrong");
    AST_BW: assert property (tk && mark_q |-> data[31:16] == 16'h0000)
        else $error("Bin width word wrong after marker");
    AST_KIND: assert property (tk && is_mark |-> mk_q < 6'h29 && (data[7:0] == kind || data[7:0] == 8'h85))
        else $error("Block marker kind out of order");
    AST_COUNT: assert property (tk && open_q && (is_hi || is_eos) |-> mk_q == 6'h29)
        else $error("Field closed with wrong block count");
    AST_ALIGN: assert property (tk && data[31:8] == frame_pkg::MARK_PREFIX |->
        is_hi || is_eos || (data[7:0] >= 8'h81 && data[7:0] <= 8'h85))
        else $error("Delimiter word not a whole code");

    cover property (tk && is_mark && data[7:0] == 8'h85);
    cover property (tk && open_q && is_eos);
    cover property (tk && widx_q == 3'h1 && data == frame_pkg::FIELD_TWO_START_MARKER_LO);
endmodule

// >>> bench/wavelet_field_bitstream_framer_bench.sv
// Bench joining builder and parser over one link, plus a parser fed bad words.
// Assumes the design package, interface and both ends are compiled first.
`timescale 1ns/100ps

module wavelet_field_bitstream_framer_bench;
    localparam int ORD [42] = '{6, 9, 20, 22, 19, 23, 17, 25, 16, 26, 14, 28, 13, 29, 11, 31, 10, 32,
        8, 34, 7, 35, 5, 37, 4, 38, 2, 40, 1, 41, 0, 39, 12, 36, 15, 33, 18, 30, 21, 27, 24, 3};
    localparam logic [31:0] BAD [16] = '{32'hFFFFFFFF, 32'h40000000, 32'h00000001, 32'h00000002,
        32'h00000003, 32'h84000001, 32'hFFFFFF83, 32'hFFFFFFFF, 32'h41000000, 32'h00000001,
        32'h00000002, 32'h00000003, 32'h84000001, 32'h5A000000, 32'hFFFFFFFF, 32'h40000000};
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic field_start_i = 1'b0;
    logic eos_req_i = 1'b0;
    logic zmode = 1'b0;
    logic ce_seen = 1'b1;
    logic exp_f2 = 1'b0;
    logic [95:0] tc = 96'h0;
    logic [15:0] cnt = 16'h0000;
    logic pay_ready_o, b_f2, busy_o, p_f2, p_fs, p_dr, p_tv, p_bs, p_zb, p_bwv, p_pv, p_se, p_oe;
    logic fs2, oe2;
    logic [5:0] b_num, p_bn;
    logic [7:0] p_ft;
    logic [15:0] p_bw;
    logic [31:0] p_pd;
    logic [95:0] p_tc;
    int bidx = 0;
    int pcnt = 0;
    int seq_n = 0;
    int fs2_n = 0;
    int oe2_n = 0;
    int cyc = 0;
    int bad_count = 0;
    int check_count = 0;
    wire empty = zmode && b_num[1:0] == 2'h0;
    wire last = cnt[1:0] == b_num[1:0];

    frame_link_if link();
    frame_link_if link2();

    stream_builder stream_builder_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .link(link),
        .field_start_i(field_start_i), .eos_req_i(eos_req_i), .timecode_i(tc),
        .bin_width_i({8'hB0, 2'h0, b_num}), .block_empty_i(empty), .pay_data_i({8'h5A, 2'h0, b_num, cnt}),
        .pay_valid_i(!empty), .pay_last_i(last), .pay_ready_o(pay_ready_o), .block_num_o(b_num),
        .field_two_o(b_f2), .busy_o(busy_o));
    stream_parser stream_parser_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .link(link),
        .field_two_o(p_f2), .field_start_o(p_fs), .decoder_reset_o(p_dr), .timecode_o(p_tc),
        .timecode_valid_o(p_tv), .first_type_o(p_ft), .block_start_o(p_bs), .block_num_o(p_bn),
        .zero_block_o(p_zb), .bin_width_o(p_bw), .bin_width_valid_o(p_bwv), .pay_data_o(p_pd),
        .pay_valid_o(p_pv), .seq_end_o(p_se), .order_err_o(p_oe));
    // Second parser sees only hand-made words, some of them wrong
    stream_parser stream_parser_fault_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .link(link2), .field_two_o(), .field_start_o(fs2), .decoder_reset_o(), .timecode_o(),
        .timecode_valid_o(), .first_type_o(), .block_start_o(), .block_num_o(), .zero_block_o(),
        .bin_width_o(), .bin_width_valid_o(), .pay_data_o(), .pay_valid_o(), .seq_end_o(),
        .order_err_o(oe2));
    frame_link_sva frame_link_sva_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
        .data(link.data), .valid(link.valid), .ready(link.ready));

    initial forever #5 clk_i = ~clk_i;

    // ========================================
    // Shared tasks
    task automatic check(input logic [95:0] seen, input logic [95:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_idle;
        tick(3);
        for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) tick(1);
        check(96'(busy_o), 96'(0));
        tick(10);
    endtask

    task automatic field(input logic f2, input logic z);
        zmode = z;
        exp_f2 = f2;
        tc = {32'h00123456, 32'h7890ABCD, 30'h0, f2, z};
        field_start_i = 1'b1;
        tick(1);
        field_start_i = 1'b0;
        tick(3);
        check(96'(b_f2), 96'(f2));
        if (z) begin
            tick(40);
            ce_i = 1'b0;
            tick(3);
            ce_i = 1'b1;
        end
        wait_idle;
        check(96'(bidx), 96'(41));
    endtask

    task automatic put(input logic [31:0] w);
        link2.data = w;
        link2.valid = 1'b1;
        @(posedge clk_i);
        while (!(link2.ready === 1'b1 && ce_i === 1'b1)) @(posedge clk_i);
        #1;
    endtask

    // ========================================
    // Payload counter and parser monitor
    always @(posedge clk_i) begin
        // Frozen edges take no payload word
        if (ce_i === 1'b1 && !empty && pay_ready_o === 1'b1) cnt <= #1 (last ? 16'h0000 : cnt + 16'h0001);
        ce_seen <= ce_i;
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            results;
        end
    end

    always @(negedge clk_i) begin
        // Strobes held by a low enable are counted once only
        if (reset_n_i && ce_seen) begin
            check(96'(p_oe), 96'(0));
            if (p_fs === 1'b1) begin
                check(96'(p_f2), 96'(exp_f2));
                check(96'(p_dr), 96'(1));
                bidx = -1;
            end
            if (p_tv === 1'b1) check(p_tc, tc);
            if (p_bs === 1'b1) begin
                bidx++;
                pcnt = 0;
                check(96'(p_bn), 96'(ORD[bidx]));
                check(96'(p_zb), 96'(zmode && ORD[bidx] % 4 == 0));
                check(96'(p_ft), 96'(8'h84));
            end
            if (p_bwv === 1'b1) check(96'(p_bw), 96'({8'hB0, 2'h0, 6'(ORD[bidx])}));
            if (p_pv === 1'b1) begin
                check(96'(p_pd), 96'({8'h5A, 2'h0, 6'(ORD[bidx]), 16'(pcnt)}));
                pcnt++;
            end
            if (p_se === 1'b1) seq_n++;
            if (fs2 === 1'b1) fs2_n++;
            if (oe2 === 1'b1) oe2_n++;
        end
    end

    // ========================================
    // Main sequence
    initial begin
        link2.data = 32'h0;
        link2.valid = 1'b0;
        tick(10);
        reset_n_i = 1'b1;
        field(1'b0, 1'b0);
        field(1'b1, 1'b1);
        eos_req_i = 1'b1;
        tick(1);
        eos_req_i = 1'b0;
        wait_idle;
        check(96'(seq_n), 96'(1));
        field(1'b0, 1'b0);
        for (int i = 0; i < 16; i++) put(BAD[i]);
        link2.valid = 1'b0;
        link2.data = ~BAD[15];
        tick(4);
        check(96'(oe2_n), 96'(1));
        check(96'(fs2_n), 96'(3));
        results;
    end
endmodule
